//--- parallel_lcd_bus_master_tb.sv
// Self-checking testbench for the parallel display bus master.
`timescale 1ns/10ps
module parallel_lcd_bus_master_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0, req_read_in = 1'b0, req_dummy_in = 1'b0;
  logic wr_valid_in = 1'b0, rd_ready_in = 1'b0;
  logic [31:0] req_cmd_in = 32'h0, wr_data_in = 32'h0, rd_data_out;
  logic [7:0] req_beats_in = 8'h00;
  logic [1:0] pw = 2'h2, binv = 2'h0;
  logic [4:0] pbase = 5'h00;
  logic req_ready_out, wr_ready_out, rd_valid_out, busy_out, shift_flag_out;
  logic cs_n_out, cmd_data_select_out, wr_n_out, rd_n_out;
  logic [31:0] data_in, data_out, data_oe_out;
  logic [15:0] dq_s;
  int n_mismatch = 0, checked = 0, cyc = 0;
  always #20 mclk_in = ~mclk_in;
  // Each pin carries the master when it drives, else the slave side.
  assign data_in = (data_oe_out & data_out) | (~data_oe_out & {dq_s, dq_s});
  plcdm_master i_plcdm_master (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .parallel_width_in(pw), .pin_base_in(pbase), .baud_div_in(9'h010),
    .strobe_invert_in(binv), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .req_cmd_in(req_cmd_in), .req_read_in(req_read_in), .req_dummy_in(req_dummy_in),
    .req_beats_in(req_beats_in), .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out),
    .wr_data_in(wr_data_in), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .rd_data_out(rd_data_out), .busy_out(busy_out), .shift_flag_out(shift_flag_out),
    .cs_n_out(cs_n_out), .cmd_data_select_out(cmd_data_select_out), .wr_n_out(wr_n_out),
    .rd_n_out(rd_n_out), .data_in(data_in), .data_out(data_out),
    .data_oe_out(data_oe_out));
  plcdm_slave_model i_plcdm_slave_model (.cs_n_in(cs_n_out), .rs_in(cmd_data_select_out),
    .wr_n_in(wr_n_out ^ binv[0]), .rd_n_in(rd_n_out ^ binv[1]), .dq_in(data_out[15:0]),
    .dq_out(dq_s));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // A hang is cut short here.
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Issue one request and wait until it is taken.
  task automatic do_req(input logic rd, input logic dm, input logic [7:0] nb);
    @(posedge mclk_in);
    i_plcdm_slave_model.wq.delete();
    i_plcdm_slave_model.rq.delete();
    i_plcdm_slave_model.n_rd = 0;
    req_cmd_in <= 32'h0000002c;
    req_read_in <= rd;
    req_dummy_in <= dm;
    req_beats_in <= nb;
    req_valid_in <= 1'b1;
    do @(negedge mclk_in); while (req_ready_out !== 1'b1);
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
  endtask : do_req
  // Eight beats from four words back to back; low half of a word goes first.
  task automatic burst_write();
    do_req(1'b0, 1'b0, 8'h08);
    for (int w = 0; w < 4; w++)
    begin
      wr_data_in <= {16'h0101 + 16'(2 * w), 16'h0100 + 16'(2 * w)};
      wr_valid_in <= 1'b1;
      do @(negedge mclk_in); while (wr_ready_out !== 1'b1);
      @(posedge mclk_in);
    end
    wr_valid_in <= 1'b0;
    do @(negedge mclk_in); while (busy_out !== 1'b0);
    chk("beats", 32'(i_plcdm_slave_model.wq.size()), 32'd9);
    chk("cmd", {i_plcdm_slave_model.rq[0], i_plcdm_slave_model.wq[0]}, 32'h2c);
    for (int i = 1; i < 9; i++)
      chk("wdata", {i_plcdm_slave_model.rq[i], i_plcdm_slave_model.wq[i]},
          32'h1_0100 + 32'(i - 1));
    chk("rd_idle", 32'(i_plcdm_slave_model.n_rd), 32'd0);
  endtask : burst_write
  // Read with a dummy beat, the receiver stalling before taking the word.
  task automatic dummy_read();
    do_req(1'b1, 1'b1, 8'h02);
    repeat (120) @(posedge mclk_in);
    rd_ready_in <= 1'b1;
    do @(negedge mclk_in); while (rd_valid_out !== 1'b1);
    chk("rdata", rd_data_out, 32'hc002c001);
    chk("flag", 32'(shift_flag_out), 32'h1);
    @(posedge mclk_in);
    rd_ready_in <= 1'b0;
    do @(negedge mclk_in); while (busy_out !== 1'b0);
    chk("rd_beats", 32'(i_plcdm_slave_model.n_rd), 32'd3);
    chk("wr_in_rd", 32'(i_plcdm_slave_model.wq.size()), 32'd1);
  endtask : dummy_read
  // One byte on pins four up with the write strobe inverted; only the bus pins drive.
  task automatic narrow_write();
    @(posedge mclk_in);
    pw <= 2'h1;
    pbase <= 5'h04;
    binv <= 2'h1;
    do_req(1'b0, 1'b0, 8'h01);
    wr_data_in <= 32'h000000a5;
    wr_valid_in <= 1'b1;
    do @(negedge mclk_in); while (wr_ready_out !== 1'b1);
    chk("oe", data_oe_out, 32'h00000ff0);
    @(posedge mclk_in);
    wr_valid_in <= 1'b0;
    do @(negedge mclk_in); while (busy_out !== 1'b0);
    chk("n_beats", 32'(i_plcdm_slave_model.wq.size()), 32'd2);
    chk("n_cmd", {i_plcdm_slave_model.rq[0], i_plcdm_slave_model.wq[0]},
        32'h000002c0);
    chk("n_data", {i_plcdm_slave_model.rq[1], i_plcdm_slave_model.wq[1]},
        32'h00010a50);
    chk("wr_inv_idle", 32'(wr_n_out), 32'h0);
  endtask : narrow_write
  initial
  begin
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    burst_write();
    dummy_read();
    narrow_write();
    print_verdict();
  end
endmodule : parallel_lcd_bus_master_tb

//--- plcdm_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module plcdm_buf2 #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Filling side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Draining side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][W-1:0] mem;  // Entry storage.
    logic wr;                // Next entry to write.
    logic rd;                // Next entry to read.
    logic [1:0] count;       // Words held, zero to two.
  } plcdm_buf_state_t;

  plcdm_buf_state_t s;
  plcdm_buf_state_t next_s;
  logic push;
  logic pop;

  // Ready and valid come straight from the count, so both flags are honest.
  assign in_ready_out = (s.count != 2'h2);
  assign out_valid_out = (s.count != 2'h0);
  assign out_data_out = s.mem[s.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Next state: write at the write pointer, read at the read pointer.
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = in_data_in;
      next_s.wr = ~s.wr;
    end
    if (pop)
    begin
      next_s.rd = ~s.rd;
    end
    next_s.count = 2'(s.count + {1'b0, push} - {1'b0, pop});
  end

  // State register.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // A stalled word stays put until the receiver takes it.
  property p_hold_stall;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("Buffer lost a stalled word.");

  // A full buffer refuses words.
  property p_full_refuses;
    (s.count == 2'h2) |-> !in_ready_out;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("Full buffer took a word.");

endmodule : plcdm_buf2

//--- plcdm_master.sv
// Parallel display bus master built from a chain of shift registers and a beat timer.
`timescale 1ns/10ps

module plcdm_master #(
  parameter int PINS = plcdm_pkg::PIN_COUNT
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Configuration, sampled when a request is taken.
  input wire logic [1:0] parallel_width_in,
  input wire logic [4:0] pin_base_in,
  input wire logic [plcdm_pkg::BAUD_W-1:0] baud_div_in,
  input wire logic [1:0] strobe_invert_in,
  // Transaction request.
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [31:0] req_cmd_in,
  input wire logic req_read_in,
  input wire logic req_dummy_in,
  input wire logic [plcdm_pkg::BEAT_W-1:0] req_beats_in,
  // Write data words, one per shift_buffer.
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [31:0] wr_data_in,
  // Read data words.
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [31:0] rd_data_out,
  // Status.
  output logic busy_out,
  output logic shift_flag_out,
  // Display bus pins.
  output logic cs_n_out,
  output logic cmd_data_select_out,
  output logic wr_n_out,
  output logic rd_n_out,
  input wire logic [PINS-1:0] data_in,
  output logic [PINS-1:0] data_out,
  output logic [PINS-1:0] data_oe_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    plcdm_pkg::plcdm_state_t st;   // Sequencer state.
    logic [3:0][31:0] chain;       // Chained shift_buffer registers.
    logic [15:0] tcmp;             // The timer_compare value in use.
    logic [7:0] lo;                // Baud half-period counter.
    logic [7:0] hi;                // Remaining strobe halves.
    logic run;                     // Timer running.
    logic phase;                   // Low while the strobe is asserted.
    logic rx;                      // Current beats are reads.
    logic cs;                      // Chip select asserted.
    logic rs;                      // High for data beats.
    logic rd_txn;                  // Transaction reads data.
    logic dummy;                   // A dummy read is due.
    logic [1:0] wcode;             // Latched parallel_width.
    logic [4:0] base;              // Latched base pin.
    logic [1:0] pol;               // Strobe inversion.
    logic [7:0] beats;             // Data beats.
    logic [7:0] align;             // Extra shifts to align read data.
    logic [2:0] nwords;            // Words carried by the data beats.
    logic [2:0] idx;               // Word being moved.
    logic [PINS-1:0] s1;           // Pin synchroniser, first stage.
    logic [PINS-1:0] s2;           // Second stage.
    logic [PINS-1:0] s3;           // Third stage.
    logic [PINS-1:0] pin_in;       // Pin value once the stages agree.
    logic [PINS-1:0] pin_q;        // Driven pin levels.
    logic [PINS-1:0] pin_oe;       // Pin drive enables.
  } plcdm_top_state_t;

  plcdm_top_state_t s;
  plcdm_top_state_t next_s;
  logic fire;          // Baud half period ends this cycle.
  logic last_half;     // The burst ends this cycle.
  logic edge_rise;     // Strobe releases: shift clock falls.
  logic edge_new;      // A new beat begins.
  logic [5:0] w;       // Bits per beat.
  logic [31:0] wmask;  // Mask of the beat bits.
  logic [31:0] in_bits;
  logic buf_valid;
  logic buf_ready;
  logic [12:0] tot_bits;
  logic [31:0] omask;  // Pin mask from the width in force next cycle, so a take shapes the command.

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  // The receiver may stall; UNLOAD waits on buf_ready so no word is lost.
  plcdm_buf2 #(.W(32)) u_rdbuf (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(buf_valid),
    .in_ready_out(buf_ready),
    .in_data_in(s.chain[s.idx[1:0]]),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );

  // ----------------------------------------------------------------
  // Handshakes and pins
  // ----------------------------------------------------------------
  assign req_ready_out = (s.st == plcdm_pkg::ST_IDLE);
  assign wr_ready_out = (s.st == plcdm_pkg::ST_FILL);
  assign buf_valid = (s.st == plcdm_pkg::ST_UNLOAD);
  assign busy_out = (s.st != plcdm_pkg::ST_IDLE);
  // The status flag asks for a word to fill or offers one to drain.
  assign shift_flag_out = wr_ready_out || rd_valid_out;
  assign cs_n_out = ~s.cs;
  assign cmd_data_select_out = s.rs;
  // Only the strobe of the current direction moves; the other stays idle.
  assign wr_n_out = ~(s.run && !s.phase && !s.rx) ^ s.pol[0];
  assign rd_n_out = ~(s.run && !s.phase && s.rx) ^ s.pol[1];
  assign data_out = s.pin_q;
  assign data_oe_out = s.pin_oe;

  // ----------------------------------------------------------------
  // Decode of the latched width
  // ----------------------------------------------------------------
  assign w = plcdm_pkg::width_bits(s.wcode);
  assign wmask = plcdm_pkg::width_mask(s.wcode);
  // The bus occupies consecutive pins from the base upward.
  assign in_bits = 32'(s.pin_in >> s.base) & wmask;
  assign fire = s.run && (s.lo == 8'h00);
  assign last_half = fire && (s.hi == 8'h00);
  assign edge_rise = fire && !last_half && !s.phase;
  assign edge_new = fire && !last_half && s.phase;
  assign tot_bits = 13'(req_beats_in) * 13'(plcdm_pkg::width_bits(parallel_width_in));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Three-stage pin synchroniser; a change counts when stages two and three agree.
    next_s.s1 = data_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.pin_in = s.s3;
    end
    // Timer: the low byte paces half periods, the high byte counts halves.
    if (s.run)
    begin
      if (fire)
      begin
        next_s.lo = s.tcmp[plcdm_pkg::TC_LO_MSB:plcdm_pkg::TC_LO_LSB];
        if (last_half)
        begin
          next_s.run = 1'b0;
          // Every burst must open with the strobe low half, so the phase starts over here.
          next_s.phase = 1'b0;
        end
        else
        begin
          next_s.hi = 8'(s.hi - 8'h01);
          next_s.phase = ~s.phase;
        end
      end
      else
      begin
        next_s.lo = 8'(s.lo - 8'h01);
      end
    end
    // Receive: the input shifter samples pins, the rest take from above.
    if (edge_rise && s.rx && (s.st == plcdm_pkg::ST_BURST))
    begin
      for (int i = 0; i < plcdm_pkg::NUM_SHIFTERS; i++)
      begin
        if (i == plcdm_pkg::IN_SHIFTER)
        begin
          next_s.chain[i] = (s.chain[i] >> w) | 32'(in_bits << (6'h20 - w));
        end
        else
        begin
          next_s.chain[i] = (s.chain[i] >> w) | 32'(s.chain[i + 1] << (6'h20 - w));
        end
      end
    end
    // Transmit: after the strobe high half, every shifter passes down one beat.
    if (edge_new && !s.rx)
    begin
      for (int i = 0; i < plcdm_pkg::NUM_SHIFTERS; i++)
      begin
        if (i == plcdm_pkg::IN_SHIFTER)
        begin
          next_s.chain[i] = s.chain[i] >> w;
        end
        else
        begin
          next_s.chain[i] = (s.chain[i] >> w) | 32'(s.chain[i + 1] << (6'h20 - w));
        end
      end
    end
    case (s.st)
      plcdm_pkg::ST_IDLE:
      begin
        next_s.cs = 1'b0;
        next_s.rs = 1'b1;
        if (req_valid_in)
        begin
          // Every transaction opens with one command beat, select low.
          next_s.st = plcdm_pkg::ST_CMD;
          next_s.cs = 1'b1;
          next_s.rs = 1'b0;
          next_s.rx = 1'b0;
          next_s.rd_txn = req_read_in;
          next_s.dummy = req_dummy_in;
          next_s.wcode = parallel_width_in;
          next_s.base = pin_base_in;
          next_s.pol = strobe_invert_in;
          next_s.beats = req_beats_in;
          next_s.align = 8'((plcdm_pkg::CAP_AT_W4 >> parallel_width_in) - req_beats_in);
          next_s.nwords = 3'((tot_bits + plcdm_pkg::WORD_ROUND) >> plcdm_pkg::WORD_SHIFT);
          next_s.chain = '0;
          next_s.chain[plcdm_pkg::OUT_SHIFTER] = req_cmd_in;
          // One beat: two halves, so the high byte is one.
          next_s.tcmp = {8'h01, 8'(baud_div_in[plcdm_pkg::BAUD_W-1:1] - 8'h01)};
          next_s.hi = 8'h01;
          next_s.lo = 8'(baud_div_in[plcdm_pkg::BAUD_W-1:1] - 8'h01);
          next_s.phase = 1'b0;
          next_s.run = 1'b1;
        end
      end
      plcdm_pkg::ST_CMD:
      begin
        if (last_half)
        begin
          next_s.rs = 1'b1;
          next_s.idx = 3'h0;
          next_s.chain = '0;
          if (!s.rd_txn)
          begin
            next_s.st = plcdm_pkg::ST_FILL;
          end
          else if (s.dummy)
          begin
            // A dummy read beat whose sample is thrown away.
            next_s.st = plcdm_pkg::ST_DUMMY;
            next_s.rx = 1'b1;
            next_s.hi = 8'h01;
            next_s.run = 1'b1;
          end
          else
          begin
            next_s.st = plcdm_pkg::ST_BURST;
            next_s.rx = 1'b1;
            next_s.tcmp[plcdm_pkg::TC_HI_MSB:plcdm_pkg::TC_HI_LSB] = 8'({s.beats, 1'b0} - 9'h001);
            next_s.hi = 8'({s.beats, 1'b0} - 9'h001);
            next_s.run = 1'b1;
          end
        end
      end
      plcdm_pkg::ST_DUMMY:
      begin
        if (last_half)
        begin
          next_s.st = plcdm_pkg::ST_BURST;
          next_s.tcmp[plcdm_pkg::TC_HI_MSB:plcdm_pkg::TC_HI_LSB] = 8'({s.beats, 1'b0} - 9'h001);
          next_s.hi = 8'({s.beats, 1'b0} - 9'h001);
          next_s.run = 1'b1;
        end
      end
      plcdm_pkg::ST_FILL:
      begin
        // Each word lands in the next shifter; shifter zero goes out first.
        if (wr_valid_in)
        begin
          next_s.chain[s.idx[1:0]] = wr_data_in;
          next_s.idx = 3'(s.idx + 3'h1);
          if (3'(s.idx + 3'h1) >= s.nwords)
          begin
            next_s.st = plcdm_pkg::ST_BURST;
            next_s.tcmp[plcdm_pkg::TC_HI_MSB:plcdm_pkg::TC_HI_LSB] = 8'({s.beats, 1'b0} - 9'h001);
            next_s.hi = 8'({s.beats, 1'b0} - 9'h001);
            next_s.run = 1'b1;
          end
        end
      end
      plcdm_pkg::ST_BURST:
      begin
        if (last_half)
        begin
          next_s.idx = 3'h0;
          next_s.st = s.rx ? plcdm_pkg::ST_ALIGN : plcdm_pkg::ST_IDLE;
          next_s.cs = s.rx;
        end
      end
      plcdm_pkg::ST_ALIGN:
      begin
        // Move the first beat down to bit zero of shifter zero.
        if (s.align == 8'h00)
        begin
          next_s.st = plcdm_pkg::ST_UNLOAD;
        end
        else
        begin
          next_s.align = 8'(s.align - 8'h01);
          for (int i = 0; i < plcdm_pkg::NUM_SHIFTERS; i++)
          begin
            if (i == plcdm_pkg::IN_SHIFTER)
            begin
              next_s.chain[i] = s.chain[i] >> w;
            end
            else
            begin
              next_s.chain[i] = (s.chain[i] >> w) | 32'(s.chain[i + 1] << (6'h20 - w));
            end
          end
        end
      end
      plcdm_pkg::ST_UNLOAD:
      begin
        if (buf_ready)
        begin
          next_s.idx = 3'(s.idx + 3'h1);
          if (3'(s.idx + 3'h1) >= s.nwords)
          begin
            next_s.st = plcdm_pkg::ST_IDLE;
            next_s.cs = 1'b0;
            next_s.rx = 1'b0;
          end
        end
      end
      default:
      begin
        next_s.st = plcdm_pkg::ST_IDLE;
      end
    endcase
    // Pins: shifter zero drives them while chip select is asserted, except while reading.
    omask = plcdm_pkg::width_mask(next_s.wcode);
    next_s.pin_q = PINS'((next_s.chain[plcdm_pkg::OUT_SHIFTER] & omask) << next_s.base);
    next_s.pin_oe = '0;
    if (next_s.cs && !next_s.rx)
    begin
      next_s.pin_oe = PINS'(omask << next_s.base);
    end
  end

  // State register.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] low_len;   // Cycles the strobe has been asserted.
  logic [1:0] cmd_beats; // Strobe pulses seen in the command beat.

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_len <= 9'h000;
      cmd_beats <= 2'h0;
    end
    else
    begin
      low_len <= (s.run && !s.phase) ? 9'(low_len + 9'h001) : 9'h000;
      if (s.st == plcdm_pkg::ST_IDLE)
      begin
        cmd_beats <= 2'h0;
      end
      else if (s.st == plcdm_pkg::ST_CMD && edge_rise)
      begin
        cmd_beats <= 2'(cmd_beats + 2'h1);
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_rd_idle_write;
    s.cs && !s.rx |-> rd_n_out == ~s.pol[1];
  endproperty
  a_rd_idle_write: assert property (p_rd_idle_write) else $error("Read strobe moved in a write.");

  property p_wr_idle_read;
    s.cs && s.rx |-> wr_n_out == ~s.pol[0];
  endproperty
  a_wr_idle_read: assert property (p_wr_idle_read) else $error("Write strobe moved in a read.");

  property p_cmd_select;
    s.st == plcdm_pkg::ST_CMD |-> !cmd_data_select_out && !cs_n_out;
  endproperty
  a_cmd_select: assert property (p_cmd_select) else $error("Command beat not marked low.");

  property p_open_cmd;
    $fell(cs_n_out) |-> s.st == plcdm_pkg::ST_CMD;
  endproperty
  a_open_cmd: assert property (p_open_cmd) else $error("Transaction did not open with command.");

  property p_read_release;
    s.rx |-> data_oe_out == '0;
  endproperty
  a_read_release: assert property (p_read_release) else $error("Data driven during read.");

  property p_half_len;
    s.run && !s.phase ##1 !(s.run && !s.phase)
      |-> low_len == 9'(s.tcmp[plcdm_pkg::TC_LO_MSB:plcdm_pkg::TC_LO_LSB]) + 9'h001;
  endproperty
  a_half_len: assert property (p_half_len) else $error("Strobe low half has wrong length.");

  property p_cmd_one_beat;
    $past(s.st) == plcdm_pkg::ST_CMD && s.st != plcdm_pkg::ST_CMD |-> cmd_beats == 2'h1;
  endproperty
  a_cmd_one_beat: assert property (p_cmd_one_beat) else $error("Command beat not exactly one.");

  property p_pins_from_out;
    s.pin_oe != '0 |-> s.pin_q == PINS'((s.chain[plcdm_pkg::OUT_SHIFTER] & wmask) << s.base);
  endproperty
  a_pins_from_out: assert property (p_pins_from_out) else $error("Pins not from shifter zero.");

  property p_data_stable_strobe;
    !wr_n_out ^ s.pol[0] |=> $stable(data_out) || (wr_n_out ^ s.pol[0]);
  endproperty
  a_data_stable_strobe: assert property (p_data_stable_strobe) else $error("Data moved under strobe.");

endmodule : plcdm_master

//--- plcdm_pkg.sv
// Shared constants, state encoding and width decoding for the parallel display bus master.
package plcdm_pkg;

  // ----------------------------------------------------------------
  // Structure of the shifter chain and pins
  // ----------------------------------------------------------------
  localparam int NUM_SHIFTERS = 4;      // Chained shift registers.
  localparam int SHIFT_W = 32;          // Bits per shift register.
  localparam int CHAIN_W = 128;         // Bits in the whole chain.
  localparam int PIN_COUNT = 32;        // Pins the block can drive or sample.
  localparam int BEAT_W = 8;            // Width of a beat count.
  localparam int IDX_W = 3;             // Width of a word index within the chain.
  localparam int OUT_SHIFTER = 0;       // The only shifter that drives pins.
  localparam int IN_SHIFTER = 3;        // The only shifter that samples pins.

  // ----------------------------------------------------------------
  // Timer compare layout: beat halves above, baud half period below
  // ----------------------------------------------------------------
  localparam int TC_W = 16;
  localparam int TC_HI_MSB = 15;
  localparam int TC_HI_LSB = 8;
  localparam int TC_LO_MSB = 7;
  localparam int TC_LO_LSB = 0;
  localparam int BAUD_W = 9;            // Baud divider in module clocks, even, at least 2.

  // ----------------------------------------------------------------
  // Parallel width codes: the width is four bits shifted left by the code
  // ----------------------------------------------------------------
  localparam logic [1:0] PW_4 = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  localparam logic [1:0] PW_32 = 2'h3;
  localparam logic [5:0] WIDTH_UNIT = 6'h04;
  localparam logic [7:0] CAP_AT_W4 = 8'h20;   // Chain capacity in beats at width 4.
  localparam logic [12:0] WORD_ROUND = 13'h01f;
  localparam int WORD_SHIFT = 5;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the write path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_FILL = 3'h3,
    ST_BURST = 3'h2,
    ST_ALIGN = 3'h6,
    ST_UNLOAD = 3'h7,
    ST_DUMMY = 3'h5
  } plcdm_state_t;

  // Bits moved per shift clock for a width code.
  function automatic logic [5:0] width_bits(input logic [1:0] code);
    width_bits = WIDTH_UNIT << code;
  endfunction : width_bits

  // Mask of the low bits that take part in one beat.
  function automatic logic [31:0] width_mask(input logic [1:0] code);
    logic [32:0] one;
    one = 33'h1 << width_bits(code);
    width_mask = 32'(one - 33'h1);
  endfunction : width_mask

endpackage : plcdm_pkg

//--- plcdm_slave_model.sv
// Behavioural display controller on the far side of the parallel bus.
`timescale 1ns/10ps
module plcdm_slave_model (
  // Bus strobes.
  input wire logic cs_n_in,
  input wire logic rs_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  // Data lines.
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] k;
  logic [15:0] last;
  logic [15:0] wq[$];
  logic rq[$];
  int n_rd;
  initial
  begin
    k = 16'h0000;
    last = 16'h0000;
    n_rd = 0;
  end
  // Latch each write beat with its select level on the strobe rise.
  always @(posedge wr_n_in)
    if (!cs_n_in)
    begin
      wq.push_back(dq_in);
      rq.push_back(rs_in);
    end
  always @(negedge rd_n_in)
    if (!cs_n_in)
      n_rd++;
  // Each read beat, dummy included, gets the next pattern value.
  always @(posedge rd_n_in)
    if (!cs_n_in)
    begin
      last = 16'hc000 + k;
      k++;
    end
  // Released lines show the inverse of the last value, never a held copy.
  assign dq_out = (!cs_n_in && !rd_n_in) ? 16'hc000 + k : ~last;
endmodule : plcdm_slave_model
